// ===== rtl/pmic_status_pkg.sv
// constants, field layout and helpers for the status and event-flag register bank
package pmic_status_pkg;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef logic [7:0]  byte_t;
	typedef logic [39:0] status_word_t;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam byte_t ADDR_REVISION_IDENT      = 8'h00;
	localparam byte_t ADDR_THERMAL_CHARGE      = 8'h01;
	localparam byte_t ADDR_INPUT_SUPPLY        = 8'h02;
	localparam byte_t ADDR_SHUTDOWN_LOCKOUT    = 8'h03;
	localparam byte_t ADDR_REGULATOR_LIMIT     = 8'h04;
	localparam byte_t ADDR_BATTERY_STATE       = 8'h05;
	localparam byte_t ADDR_CHARGE_EVENT_FLAGS  = 8'h06;
	localparam byte_t ADDR_CHARGE_EVENT_MASK   = 8'h0A;

	// ------------------------------------------------------------------
	// field positions and codes
	// ------------------------------------------------------------------
	localparam int ZONE_LSB          = 3;
	localparam int CHG_STATE_LSB     = 0;
	localparam int EVT_ZONE_BIT      = 7;
	localparam int EVT_CHG_STATE_BIT = 6;
	// byte lanes of the sampled status word (thermal_charge_state at the bottom)
	localparam int LANE_THERMAL_CHARGE   = 0;
	localparam int LANE_INPUT_SUPPLY     = 8;
	localparam int LANE_SHUTDOWN_LOCKOUT = 16;
	localparam int LANE_REGULATOR_LIMIT  = 24;
	localparam int LANE_BATTERY_STATE    = 32;

	localparam logic [2:0] ZONE_MONITOR_OFF  = 3'b110;
	localparam logic [2:0] ZONE_INPUT_ABSENT = 3'b111;
	localparam logic [1:0] THM_ENABLE_OFF    = 2'b00;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam byte_t        FLAGS_RESET   = 8'h00;
	localparam byte_t        MASK_RESET    = 8'h00;
	localparam byte_t        RDATA_RESET   = 8'h00;
	localparam status_word_t STATUS_RESET  = 40'h00_0000_0000;
	// arbitrary neutral value, not tied to any real part
	localparam byte_t        DEFAULT_HW_REVISION = 8'h01;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [2:0] zone_code(input logic [2:0] band,
		input logic charge_in, input logic [1:0] chg_en, input logic [1:0] hrv_en);
		logic [2:0] code;
		code = band;
		if (charge_in && chg_en == THM_ENABLE_OFF)
			code = ZONE_MONITOR_OFF;
		else if (!charge_in && hrv_en == THM_ENABLE_OFF)
			code = (chg_en == THM_ENABLE_OFF) ? ZONE_MONITOR_OFF : ZONE_INPUT_ABSENT;
		return code;
	endfunction : zone_code

	function automatic byte_t watched_changes(input status_word_t old_w,
		input status_word_t new_w);
		byte_t chg;
		chg = new_w[LANE_INPUT_SUPPLY +: 8] ^ old_w[LANE_INPUT_SUPPLY +: 8];
		chg[EVT_ZONE_BIT] = new_w[ZONE_LSB +: 3] != old_w[ZONE_LSB +: 3];
		chg[EVT_CHG_STATE_BIT] = new_w[CHG_STATE_LSB +: 3] != old_w[CHG_STATE_LSB +: 3];
		return chg;
	endfunction : watched_changes

endpackage : pmic_status_pkg

// ===== rtl/status_event_if.sv
// carrier for sampled status and change events between the bank's modules
`timescale 1ns/1ps
`default_nettype none

interface status_event_if;
	import pmic_status_pkg::*;

	status_word_t status_word;
	byte_t        change_evt;

	modport sampler (output status_word, output change_evt);
	modport monitor (input status_word, input change_evt);
endinterface : status_event_if

`default_nettype wire

// ===== rtl/status_sampler.sv
// samples composed status into the clock domain and emits change events
`timescale 1ns/1ps
`default_nettype none

module status_sampler
	import pmic_status_pkg::*;
(
	// clock, reset, enable
	input  wire logic     i_ref_clk,
	input  wire logic     i_rst,
	input  wire logic     i_ce,
	// composed status
	input  wire logic [39:0] i_status_word,
	// sampled status and events
	status_event_if.sampler  evt_bus
);

	status_word_t status_reg,  status_next;
	byte_t        evt_reg,     evt_next;
	logic         primed_reg,  primed_next;

	always_comb begin
		status_next = status_reg;
		// a registered event waits out a freeze so the flag bank still applies it
		evt_next    = evt_reg;
		primed_next = primed_reg;
		if (i_ce) begin
			evt_next    = 8'h00;
			status_next = i_status_word;
			primed_next = 1'b1;
			// first sample after reset is not a change
			if (primed_reg)
				evt_next = watched_changes(status_reg, i_status_word);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			status_reg <= STATUS_RESET;
			evt_reg    <= 8'h00;
			primed_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			evt_reg    <= evt_next;
			primed_reg <= primed_next;
		end
	end

	assign evt_bus.status_word = status_reg;
	assign evt_bus.change_evt  = evt_reg;

	a_one_event_per_change: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && primed_reg) |=> (evt_reg == watched_changes($past(status_reg), status_reg)))
		else $error("change event does not match sampled status change");

endmodule : status_sampler

`default_nettype wire

// ===== rtl/event_flag_bank.sv
// sticky change flags with write-one-to-clear and a mask register
`timescale 1ns/1ps
`default_nettype none

module event_flag_bank
	import pmic_status_pkg::*;
(
	// clock, reset, enable
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	// events
	status_event_if.monitor evt_bus,
	// software access
	input  wire logic       i_clear_wr,
	input  wire logic       i_mask_wr,
	input  wire logic [7:0] i_wdata,
	// state
	output logic      [7:0] o_flags,
	output logic      [7:0] o_mask
);

	byte_t flags_reg, flags_next;
	byte_t mask_reg,  mask_next;

	always_comb begin
		flags_next = flags_reg;
		mask_next  = mask_reg;
		if (i_ce) begin
			if (i_clear_wr)
				flags_next = flags_reg & ~i_wdata;
			// a set in the clearing cycle wins
			flags_next = flags_next | evt_bus.change_evt;
			if (i_mask_wr)
				mask_next = i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			flags_reg <= FLAGS_RESET;
			mask_reg  <= MASK_RESET;
		end else begin
			flags_reg <= flags_next;
			mask_reg  <= mask_next;
		end
	end

	assign o_flags = flags_reg;
	assign o_mask  = mask_reg;

	a_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!(i_ce && i_clear_wr)) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
		else $error("event flag dropped without a clear write");

	a_set_wins_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && evt_bus.change_evt != 8'h00)
		|=> ((flags_reg & $past(evt_bus.change_evt)) == $past(evt_bus.change_evt)))
		else $error("change event did not set its flag");

endmodule : event_flag_bank

`default_nettype wire

// ===== rtl/pmic_status_interrupt_regs.sv
// status registers and first change-flag register of the power-management device
`timescale 1ns/1ps
`default_nettype none

module pmic_status_interrupt_regs
	import pmic_status_pkg::*;
#(
	parameter byte_t HW_REVISION = DEFAULT_HW_REVISION
)(
	// clock, reset, enable
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	// register port
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_rd,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	// thermistor and charger
	input  wire logic [2:0] i_thermistor_band,
	input  wire logic       i_charge_input,
	input  wire logic [1:0] i_charge_thermistor_enable,
	input  wire logic [1:0] i_harvest_thermistor_enable,
	input  wire logic [2:0] i_charger_state,
	// input supply
	input  wire logic       i_input_current_limited,
	input  wire logic       i_input_overvoltage,
	input  wire logic       i_input_valid,
	input  wire logic       i_temp_profile_shutdown,
	input  wire logic       i_temp_profile_reduction,
	input  wire logic       i_charge_timeout,
	// shutdowns and lockouts
	input  wire logic       i_charger_thermal_shutdown,
	input  wire logic [3:0] i_linear_switch_thermal,
	input  wire logic       i_linreg2_undervoltage,
	input  wire logic       i_linreg1_undervoltage,
	// regulators and limits
	input  wire logic       i_buckboost_fault,
	input  wire logic       i_harvest_battery_compare,
	input  wire logic       i_system_rail_limit,
	input  wire logic       i_input_rail_limit,
	input  wire logic       i_step_charge_active,
	input  wire logic       i_buck_a_thermal_shutdown,
	input  wire logic       i_buck_b_thermal_shutdown,
	input  wire logic       i_buck_c_thermal_shutdown,
	// battery
	input  wire logic       i_battery_above_uvlo,
	input  wire logic       i_battery_regulation_reached,
	input  wire logic       i_boost_fault,
	// event summary
	output logic            o_charge_event_pending
);

	// ------------------------------------------------------------------
	// status composition
	// ------------------------------------------------------------------
	byte_t        thermal_charge_byte;
	byte_t        input_supply_byte;
	byte_t        shutdown_lockout_byte;
	byte_t        regulator_limit_byte;
	byte_t        battery_byte;
	status_word_t composed_word;
	logic [2:0]   zone_now;

	always_comb begin
		zone_now = zone_code(i_thermistor_band, i_charge_input,
			i_charge_thermistor_enable, i_harvest_thermistor_enable);
		thermal_charge_byte = {2'b00, zone_now, i_charger_state};
		// validity qualifiers are left to software; raw levels are reported
		input_supply_byte = {2'b00,
			i_input_current_limited,
			i_input_overvoltage,
			i_input_valid,
			i_temp_profile_shutdown,
			i_temp_profile_reduction,
			i_charge_timeout};
		shutdown_lockout_byte = {i_charger_thermal_shutdown, 1'b0,
			|i_linear_switch_thermal,
			i_linreg2_undervoltage,
			i_linreg1_undervoltage,
			3'b000};
		regulator_limit_byte = {i_buckboost_fault,
			i_harvest_battery_compare,
			i_system_rail_limit,
			i_input_rail_limit,
			i_step_charge_active,
			i_buck_a_thermal_shutdown,
			i_buck_b_thermal_shutdown,
			i_buck_c_thermal_shutdown};
		battery_byte = {i_battery_above_uvlo | ~i_charge_input,
			i_battery_regulation_reached,
			i_boost_fault,
			5'b00000};
		composed_word = {battery_byte, regulator_limit_byte, shutdown_lockout_byte,
			input_supply_byte, thermal_charge_byte};
	end

	// ------------------------------------------------------------------
	// sampling and flags
	// ------------------------------------------------------------------
	status_event_if evt_bus ();

	byte_t flags;
	byte_t mask;
	logic  clear_wr;
	logic  mask_wr;

	assign clear_wr = i_reg_wr && i_reg_addr == ADDR_CHARGE_EVENT_FLAGS;
	assign mask_wr  = i_reg_wr && i_reg_addr == ADDR_CHARGE_EVENT_MASK;

	status_sampler u_sampler (
		.i_ref_clk     (i_ref_clk),
		.i_rst         (i_rst),
		.i_ce          (i_ce),
		.i_status_word (composed_word),
		.evt_bus       (evt_bus.sampler)
	);

	event_flag_bank u_flags (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.evt_bus    (evt_bus.monitor),
		.i_clear_wr (clear_wr),
		.i_mask_wr  (mask_wr),
		.i_wdata    (i_reg_wdata),
		.o_flags    (flags),
		.o_mask     (mask)
	);

	assign o_charge_event_pending = |(flags & mask);

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	byte_t rdata_reg,  rdata_next;
	logic  rvalid_reg, rvalid_next;
	byte_t read_mux;

	always_comb begin
		case (i_reg_addr)
			ADDR_REVISION_IDENT:     read_mux = HW_REVISION;
			ADDR_THERMAL_CHARGE:     read_mux = evt_bus.status_word[LANE_THERMAL_CHARGE +: 8];
			ADDR_INPUT_SUPPLY:       read_mux = evt_bus.status_word[LANE_INPUT_SUPPLY +: 8];
			ADDR_SHUTDOWN_LOCKOUT:   read_mux = evt_bus.status_word[LANE_SHUTDOWN_LOCKOUT +: 8];
			ADDR_REGULATOR_LIMIT:    read_mux = evt_bus.status_word[LANE_REGULATOR_LIMIT +: 8];
			ADDR_BATTERY_STATE:      read_mux = evt_bus.status_word[LANE_BATTERY_STATE +: 8];
			ADDR_CHARGE_EVENT_FLAGS: read_mux = flags;
			ADDR_CHARGE_EVENT_MASK:  read_mux = mask;
			default:                 read_mux = RDATA_RESET;
		endcase
	end

	always_comb begin
		rdata_next  = rdata_reg;
		rvalid_next = rvalid_reg;
		if (i_ce) begin
			rvalid_next = i_reg_rd;
			if (i_reg_rd)
				rdata_next = read_mux;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg  <= RDATA_RESET;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign o_reg_rdata  = rdata_reg;
	assign o_reg_rvalid = rvalid_reg;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	a_revision_read: assert property (
		(i_ce && i_reg_rd && i_reg_addr == ADDR_REVISION_IDENT)
		|=> (o_reg_rvalid && o_reg_rdata == HW_REVISION))
		else $error("revision read returned wrong value");

	a_zone_band: assert property (
		(i_ce && i_charge_input && i_charge_thermistor_enable != THM_ENABLE_OFF)
		|=> (evt_bus.status_word[ZONE_LSB +: 3] == $past(i_thermistor_band)))
		else $error("zone field does not follow thermistor band");

	a_zone_disabled: assert property (
		(i_ce && !i_charge_input && i_charge_thermistor_enable != THM_ENABLE_OFF
			&& i_harvest_thermistor_enable == THM_ENABLE_OFF)
		|=> (evt_bus.status_word[ZONE_LSB +: 3] == ZONE_INPUT_ABSENT))
		else $error("zone field not 111 with input absent");

	a_charger_state: assert property (
		i_ce |=> (evt_bus.status_word[CHG_STATE_LSB +: 3] == $past(i_charger_state)))
		else $error("charger state field mismatch");

	a_supply_bits: assert property (
		i_ce |=> (evt_bus.status_word[LANE_INPUT_SUPPLY +: 6] ==
			$past({i_input_current_limited, i_input_overvoltage, i_input_valid,
			i_temp_profile_shutdown, i_temp_profile_reduction, i_charge_timeout})))
		else $error("input supply bits mismatch");

	a_linear_thermal: assert property (
		(i_ce && i_linear_switch_thermal == 4'h0)
		|=> !evt_bus.status_word[LANE_SHUTDOWN_LOCKOUT + 5])
		else $error("linear thermal bit set with all blocks normal");

	a_battery_good: assert property (
		(i_ce && !i_charge_input) |=> evt_bus.status_word[LANE_BATTERY_STATE + 7])
		else $error("battery good not forced high without input");

	a_charger_thermal: assert property (
		i_ce |=> (evt_bus.status_word[LANE_SHUTDOWN_LOCKOUT + 7]
			== $past(i_charger_thermal_shutdown)))
		else $error("charger thermal shutdown bit mismatch");

	a_linear_thermal_set: assert property (
		(i_ce && i_linear_switch_thermal != 4'h0)
		|=> evt_bus.status_word[LANE_SHUTDOWN_LOCKOUT + 5])
		else $error("linear thermal bit clear with a block in shutdown");

	a_lockout_bits: assert property (
		i_ce |=> (evt_bus.status_word[(LANE_SHUTDOWN_LOCKOUT + 3) +: 2]
			== $past({i_linreg2_undervoltage, i_linreg1_undervoltage})))
		else $error("regulator lockout bits mismatch");

	a_regulator_bits: assert property (
		i_ce |=> (evt_bus.status_word[LANE_REGULATOR_LIMIT +: 8] == $past({i_buckboost_fault,
			i_harvest_battery_compare, i_system_rail_limit, i_input_rail_limit,
			i_step_charge_active, i_buck_a_thermal_shutdown, i_buck_b_thermal_shutdown,
			i_buck_c_thermal_shutdown})))
		else $error("regulator limit bits mismatch");

	a_battery_compare: assert property (
		(i_ce && i_charge_input)
		|=> (evt_bus.status_word[LANE_BATTERY_STATE + 7] == $past(i_battery_above_uvlo)))
		else $error("battery good does not follow comparator");

	a_regulation_done: assert property (
		i_ce |=> (evt_bus.status_word[LANE_BATTERY_STATE + 6]
			== $past(i_battery_regulation_reached)))
		else $error("regulation reached bit mismatch");

	a_zone_monitor_off: assert property (
		(i_ce && i_charge_input && i_charge_thermistor_enable == THM_ENABLE_OFF)
		|=> (evt_bus.status_word[ZONE_LSB +: 3] == ZONE_MONITOR_OFF))
		else $error("zone field not 110 with monitoring off");

	a_flag_read: assert property (
		(i_ce && i_reg_rd && i_reg_addr == ADDR_CHARGE_EVENT_FLAGS)
		|=> (o_reg_rdata == $past(flags)))
		else $error("flag read does not return the flag register");

	a_state_read_path: assert property (
		(i_ce && i_reg_rd && i_reg_addr == ADDR_INPUT_SUPPLY)
		|=> (o_reg_rdata == $past(evt_bus.status_word[LANE_INPUT_SUPPLY +: 8])))
		else $error("status read not taken from sampled status");

	a_pending_masked: assert property (
		(mask == 8'h00) |-> !o_charge_event_pending)
		else $error("pending raised with all flags masked");

	a_frozen_when_idle: assert property (
		!i_ce |=> $stable(o_reg_rdata) && $stable(flags) && $stable(mask))
		else $error("state moved while clock enable low");

	c_zone_event: cover property (i_ce && evt_bus.change_evt[EVT_ZONE_BIT]);
	c_clear_flags: cover property (i_ce && clear_wr && flags != 8'h00);
	c_set_and_clear: cover property (i_ce && clear_wr && evt_bus.change_evt != 8'h00);
	c_pending: cover property ($rose(o_charge_event_pending));
	c_frozen_event: cover property (!i_ce && evt_bus.change_evt != 8'h00);

endmodule : pmic_status_interrupt_regs

`default_nettype wire

// ===== bench/host_reg_model.sv
// host-side register access model for the status bank
`timescale 1ns/1ps
`default_nettype none

module host_reg_model
	import pmic_status_pkg::*;
(
	// clock and read answer
	input  wire logic  i_ref_clk,
	input  wire byte_t i_rdata,
	input  wire logic  i_rvalid,
	// request
	output byte_t      o_addr,
	output logic       o_rd,
	output logic       o_wr,
	output byte_t      o_wdata
);
	initial begin
		o_addr = 8'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end

	task automatic reg_write(input byte_t a, input byte_t d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_ref_clk);
		o_wr <= 1'b0;
	endtask : reg_write

	// data is taken at the edge that samples the one-cycle valid
	task automatic reg_read(input byte_t a, output byte_t d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge i_ref_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_ref_clk);
		o_rd <= 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge i_ref_clk);
			if (i_rvalid === 1'b1) begin
				d = i_rdata;
				ok = 1'b1;
			end
		end
	endtask : reg_read
endmodule : host_reg_model

`default_nettype wire

// ===== bench/test_pmic_status_interrupt_regs.sv
// self-checking bench for the status and event-flag register bank
`timescale 1ns/1ps
`default_nettype none

module test_pmic_status_interrupt_regs;
	import pmic_status_pkg::*;

	localparam byte_t REV = 8'h5A;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [2:0]  band = 3'h0;
	logic [2:0]  cstate = 3'h0;
	logic        cin = 1'b1;
	logic [1:0]  cen = 2'h1;
	logic [1:0]  hen = 2'h1;
	// status inputs packed as {battery, regulator, shutdown, supply}
	logic [23:0] w = 24'h000000;
	byte_t       addr;
	byte_t       wdata;
	byte_t       rdata;
	logic        rd;
	logic        wr;
	logic        rvalid;
	logic        pending;
	int          miscompares = 0;
	int          check_count = 0;

	always #4 clk = ~clk;

	pmic_status_interrupt_regs #(.HW_REVISION(REV)) DUT (
		.i_ref_clk(clk), .i_rst(rst), .i_ce(ce),
		.i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_thermistor_band(band), .i_charge_input(cin),
		.i_charge_thermistor_enable(cen), .i_harvest_thermistor_enable(hen),
		.i_charger_state(cstate),
		.i_input_current_limited(w[5]), .i_input_overvoltage(w[4]),
		.i_input_valid(w[3]), .i_temp_profile_shutdown(w[2]),
		.i_temp_profile_reduction(w[1]), .i_charge_timeout(w[0]),
		.i_charger_thermal_shutdown(w[12]), .i_linear_switch_thermal(w[11:8]),
		.i_linreg2_undervoltage(w[7]), .i_linreg1_undervoltage(w[6]),
		.i_buckboost_fault(w[20]), .i_harvest_battery_compare(w[19]),
		.i_system_rail_limit(w[18]), .i_input_rail_limit(w[17]),
		.i_step_charge_active(w[16]), .i_buck_a_thermal_shutdown(w[15]),
		.i_buck_b_thermal_shutdown(w[14]), .i_buck_c_thermal_shutdown(w[13]),
		.i_battery_above_uvlo(w[23]), .i_battery_regulation_reached(w[22]),
		.i_boost_fault(w[21]),
		.o_charge_event_pending(pending)
	);

	host_reg_model host (
		.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata)
	);

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic chk8(input byte_t got, input byte_t exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk1

	// a missing read answer ends the run at once
	task automatic rdchk(input byte_t a, input byte_t exp);
		byte_t d;
		logic  ok;
		host.reg_read(a, d, ok);
		if (!ok) begin
			miscompares++;
			$display("Error at %0t: no read answer from %h", $time, a);
			finish_test();
		end else begin
			chk8(d, exp);
		end
	endtask : rdchk

	// lets sampling, event and flag stages all land
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic test_ident;
		rdchk(ADDR_REVISION_IDENT, REV);
		rdchk(8'h20, 8'h00);
		rdchk(ADDR_CHARGE_EVENT_MASK, 8'h00);
		rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'h00);
		$display("test ident done");
	endtask : test_ident

	// fields {input, charge enable, harvest enable, band, expected zone}
	task automatic test_zone;
		logic [10:0] zt [9];
		zt = '{11'b1_01_01_000_000, 11'b1_01_01_001_001, 11'b1_10_00_010_010,
			11'b1_11_01_011_011, 11'b0_01_01_100_100, 11'b0_00_11_101_101,
			11'b1_00_01_010_110, 11'b0_00_00_010_110, 11'b0_01_00_011_111};
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			{cin, cen, hen, band} <= zt[i][10:3];
			cstate <= i[2:0];
			settle();
			rdchk(ADDR_THERMAL_CHARGE, {2'b00, zt[i][2:0], i[2:0]});
		end
		@(posedge clk);
		{cin, cen, hen, band, cstate} <= {1'b1, 2'h1, 2'h1, 3'h2, 3'h3};
		settle();
		$display("test zone done");
	endtask : test_zone

	task automatic test_bits;
		for (int k = 0; k < 24; k++) begin
			@(posedge clk);
			w <= 24'h000001 << k;
			settle();
			rdchk(ADDR_INPUT_SUPPLY, {2'b00, w[5:0]});
			rdchk(ADDR_SHUTDOWN_LOCKOUT, {w[12], 1'b0, |w[11:8], w[7:6], 3'h0});
			rdchk(ADDR_REGULATOR_LIMIT, w[20:13]);
			rdchk(ADDR_BATTERY_STATE, {w[23:21], 5'h00});
		end
		host.reg_write(ADDR_BATTERY_STATE, 8'hFF);
		@(posedge clk);
		cin <= 1'b0;
		w <= 24'h000000;
		settle();
		rdchk(ADDR_BATTERY_STATE, 8'h80);
		@(posedge clk);
		cin <= 1'b1;
		settle();
		rdchk(ADDR_BATTERY_STATE, 8'h00);
		$display("test bits done");
	endtask : test_bits

	task automatic test_events;
		host.reg_write(ADDR_CHARGE_EVENT_MASK, 8'hFF);
		host.reg_write(ADDR_CHARGE_EVENT_FLAGS, 8'hFF);
		settle();
		rdchk(ADDR_CHARGE_EVENT_MASK, 8'hFF);
		rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'h00);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			w <= 24'h000001 << k;
			settle();
			rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'h01 << k);
			chk1(pending, 1'b1);
			@(posedge clk);
			w <= 24'h000000;
			settle();
			rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'h01 << k);
			host.reg_write(ADDR_CHARGE_EVENT_FLAGS, 8'hFF);
			settle();
			rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'h00);
			chk1(pending, 1'b0);
		end
		@(posedge clk);
		band <= 3'h4;
		cstate <= 3'h5;
		settle();
		rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'hC0);
		host.reg_write(ADDR_CHARGE_EVENT_MASK, 8'h3F);
		settle();
		chk1(pending, 1'b0);
		host.reg_write(ADDR_CHARGE_EVENT_MASK, 8'h80);
		settle();
		chk1(pending, 1'b1);
		host.reg_write(ADDR_CHARGE_EVENT_FLAGS, 8'h40);
		rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'h80);
		$display("test events done");
	endtask : test_events

	// an event registered just before a freeze must still reach its flag
	task automatic test_freeze;
		host.reg_write(ADDR_CHARGE_EVENT_MASK, 8'hFF);
		host.reg_write(ADDR_CHARGE_EVENT_FLAGS, 8'hFF);
		@(posedge clk);
		w <= 24'h000008;
		@(posedge clk);
		ce <= 1'b0;
		// refused while frozen: the mask must stay open
		host.reg_write(ADDR_CHARGE_EVENT_MASK, 8'h00);
		repeat (4) @(posedge clk);
		chk1(pending, 1'b0);
		@(posedge clk);
		ce <= 1'b1;
		settle();
		rdchk(ADDR_CHARGE_EVENT_FLAGS, 8'h08);
		chk1(pending, 1'b1);
		$display("test freeze done");
	endtask : test_freeze

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		test_ident();
		test_zone();
		test_bits();
		test_events();
		test_freeze();
		finish_test();
	end
endmodule : test_pmic_status_interrupt_regs

`default_nettype wire
